/* File: sts_supervisor.sv */
// self-test and random generator supervisor
`timescale 1ns/1ns
`include "sts_defs.svh"

// Behaviour
// - seed main generator with 512 entropy bits
// - seed released only with 414 bits entropy
// - stir random command reseeds main generator
// - transient generator serves primary key requests only
// - tests run automatically, or on command
// - test failure returns failure code, enters failure
// - failure blocks crypto work and data output
// - failure accepts only result and capability queries
// - failure left only through reset
// - no success flag, dependent commands just work
// - firmware checked with ISO CRC-16 against reference
// - full test reruns CRC, reported in bit 1
// - hardware sensor flags checked during boot
// - repetition and proportion health tests on entropy
// - generator test: 64-byte seed, 32-byte output
// - hash tests: 16 bytes in, bits 1-3
// - result response: status word, then algorithm list
module sts_supervisor
  import sts_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire sts_cmd_s cmd,
  output logic cmd_ready,
  output sts_rsp_s rsp,
  output logic [31:0] status_code,
  output logic failure,
  input wire sts_ent_s ent,
  output logic ent_ready,
  output logic [511:0] main_generator_seed,
  output logic main_seed_valid,
  input wire logic [7:0] hw_sensor_flags,
  output logic fw_req,
  input wire sts_fw_s fw,
  input wire logic [15:0] fw_crc_ref,
  output logic kat_start,
  output sts_test_e kat_sel,
  output sts_kat_cfg_s kat_cfg,
  input wire logic kat_done,
  input wire logic kat_pass,
  input wire logic rnd_req,
  input wire logic rnd_primary,
  output logic main_gen_req,
  output logic transient_gen_req,
  output logic crypto_enable,
  output logic data_out_enable
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `STS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [31:0] result_word(input logic f, input logic [31:0] a);
    if (f) begin
      return `STS_RC_FAILURE;
    end
    return (a != 32'h00000000) ? `STS_RC_TESTING : `STS_RC_SUCCESS;
  endfunction

  function automatic sts_kat_cfg_s kat_cfg_of(input sts_test_e t);
    sts_kat_cfg_s c;
    c.seed_len = 7'd0;
    c.msg_len = `STS_KAT_MSG_LEN;
    c.out_len = `STS_KAT_SHA1_OUT;
    case (t)
      T_DRBG: begin
        c.seed_len = `STS_KAT_SEED_LEN;
        c.msg_len = 7'd0;
        c.out_len = `STS_KAT_DRBG_OUT;
      end
      T_SHA256: c.out_len = `STS_KAT_SHA256_OUT;
      T_SHA384: c.out_len = `STS_KAT_SHA384_OUT;
      default: c.out_len = `STS_KAT_SHA1_OUT;
    endcase
    return c;
  endfunction

  // ==========================================================
  // state
  sts_reg_s s;
  sts_reg_s next_s;
  logic seed_ready;
  logic ent_take;
  logic go_fail;
  logic [10:0] credit_sum;

  assign seed_ready = (s.nbytes == `STS_SEED_BYTES) && (s.credit >= `STS_MIN_ENTROPY);
  assign ent_ready = ((s.st == ST_ENT) || (s.st == ST_RESEED)) && !seed_ready;
  assign ent_take = ent.valid && ent_ready;
  assign credit_sum = {1'b0, s.credit} + {7'h00, ent.credit};

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    go_fail = 1'b0;
    next_s.seed_vld = 1'b0;
    next_s.kat_start = 1'b0;
    next_s.rsp.valid = 1'b0;

    // seed collection and health tests
    if (ent_take) begin
      next_s.seed = {s.seed[503:0], ent.data};
      if (s.nbytes != `STS_SEED_BYTES) begin
        next_s.nbytes = s.nbytes + 7'd1;
      end
      next_s.credit = credit_sum[10] ? `STS_CREDIT_MAX : credit_sum[9:0];
      next_s.have = 1'b1;
      next_s.last = ent.data;
      if (s.have && (ent.data == s.last)) begin
        next_s.repetition_count_test = s.repetition_count_test + 3'd1;
        if (s.repetition_count_test == (`STS_RCT_CUTOFF - 3'd2)) begin
          go_fail = 1'b1;
        end
      end else begin
        next_s.repetition_count_test = 3'd0;
      end
      next_s.apt_n = s.apt_n + 9'd1;
      if (s.apt_n == 9'd0) begin
        next_s.apt_ref = ent.data;
        next_s.apt_cnt = 5'd1;
      end else if (ent.data == s.apt_ref) begin
        next_s.apt_cnt = s.apt_cnt + 5'd1;
        if (s.apt_cnt == (`STS_APT_CUTOFF - 5'd1)) begin
          go_fail = 1'b1;
        end
      end
    end

    case (s.st)
      ST_HW: begin
        if (hw_sensor_flags != 8'h00) begin
          go_fail = 1'b1;
        end else begin
          next_s.st = ST_ENT;
        end
      end
      ST_ENT, ST_RESEED: begin
        if (seed_ready) begin
          next_s.seed_vld = 1'b1;
          next_s.seed_out = s.seed;
          next_s.nbytes = 7'd0;
          next_s.credit = 10'd0;
          if (s.st == ST_ENT) begin
            next_s.st = ST_CRC;
          end else begin
            next_s.st = ST_IDLE;
            next_s.pend = 1'b0;
            next_s.rsp = '{1'b1, `STS_RC_SUCCESS, 32'h00000000};
          end
        end
      end
      ST_CRC: begin
        if (fw.valid) begin
          next_s.crc = crc16_byte(s.crc, fw.data);
          if (fw.last) begin
            next_s.crc = `STS_CRC_INIT;
            if ((crc16_byte(s.crc, fw.data) ^ `STS_CRC_XOROUT) == fw_crc_ref) begin
              next_s.crc_ok = 1'b1;
              next_s.st = ST_KAT;
              next_s.tst = T_DRBG;
            end else begin
              go_fail = 1'b1;
            end
          end
        end
      end
      ST_KAT: begin
        if (!s.kat_busy) begin
          next_s.kat_start = 1'b1;
          next_s.kat_busy = 1'b1;
        end else if (kat_done) begin
          next_s.kat_busy = 1'b0;
          if (!kat_pass) begin
            go_fail = 1'b1;
          end else begin
            case (s.tst)
              T_SHA1: next_s.algo[`STS_BIT_SHA1] = !s.crc_ok;
              T_SHA256: next_s.algo[`STS_BIT_SHA256] = 1'b0;
              T_SHA384: next_s.algo[`STS_BIT_SHA384] = 1'b0;
              default: next_s.algo = s.algo;
            endcase
            if (s.tst == T_SHA384) begin
              next_s.st = ST_IDLE;
              if (s.pend) begin
                next_s.pend = 1'b0;
                next_s.rsp = '{1'b1, `STS_RC_SUCCESS, 32'h00000000};
              end
            end else begin
              next_s.tst = sts_test_e'(s.tst + 2'd1);
            end
          end
        end
      end
      ST_IDLE: begin
        if (cmd.valid) begin
          case (cmd.code)
            CMD_STIR: begin
              next_s.st = ST_RESEED;
              next_s.nbytes = 7'd0;
              next_s.credit = 10'd0;
              next_s.pend = 1'b1;
            end
            CMD_FULL, CMD_INCR: begin
              next_s.pend = 1'b1;
              next_s.tst = T_DRBG;
              if ((cmd.code == CMD_FULL) && cmd.full) begin
                next_s.crc_ok = 1'b0;
                next_s.algo = s.algo | `STS_ALGO_RESET;
                next_s.crc = `STS_CRC_INIT;
                next_s.st = ST_CRC;
              end else begin
                next_s.st = ST_KAT;
              end
            end
            CMD_RESULT: next_s.rsp = '{1'b1, result_word(s.failed, s.algo), s.algo};
            default: next_s.rsp = '{1'b1, `STS_RC_SUCCESS, 32'h00000000};
          endcase
        end
      end
      ST_FAIL: begin
        if (cmd.valid) begin
          case (cmd.code)
            CMD_RESULT: next_s.rsp = '{1'b1, result_word(s.failed, s.algo), s.algo};
            CMD_CAP: next_s.rsp = '{1'b1, `STS_RC_SUCCESS, 32'h00000000};
            default: next_s.rsp = '{1'b1, `STS_RC_FAILURE, 32'h00000000};
          endcase
        end
      end
      default: go_fail = 1'b1;
    endcase

    if (go_fail && (s.st != ST_FAIL)) begin
      next_s.st = ST_FAIL;
      next_s.failed = 1'b1;
      next_s.kat_busy = 1'b0;
      next_s.pend = 1'b0;
      next_s.rsp = '{1'b1, `STS_RC_FAILURE, s.algo};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
      s.st <= ST_HW;
      s.algo <= `STS_ALGO_RESET;
      s.crc <= `STS_CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign cmd_ready = (s.st == ST_IDLE) || (s.st == ST_FAIL);
  assign rsp = s.rsp;
  assign status_code = s.failed ? `STS_RC_FAILURE : `STS_RC_SUCCESS;
  assign failure = s.failed;
  assign main_generator_seed = s.seed_out;
  assign main_seed_valid = s.seed_vld;
  assign fw_req = (s.st == ST_CRC);
  assign kat_start = s.kat_start;
  assign kat_sel = s.tst;
  assign kat_cfg = kat_cfg_of(s.tst);
  assign crypto_enable = (s.st == ST_IDLE) && !s.failed;
  assign data_out_enable = !s.failed;
  assign main_gen_req = rnd_req && !rnd_primary && crypto_enable;
  assign transient_gen_req = rnd_req && rnd_primary && crypto_enable;

  // ==========================================================
  // checks
  a_fail_sticky: assert property (@(posedge clk) disable iff (!nrst)
    s.failed |=> (s.failed && (s.st == ST_FAIL)))
    else $error("failure state was left without reset");
  a_fail_blocks: assert property (@(posedge clk) disable iff (!nrst)
    s.failed |-> (!data_out_enable && !crypto_enable && !main_gen_req && !transient_gen_req))
    else $error("output or crypto work not blocked in failure");
  a_fail_rejects: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == ST_FAIL && cmd.valid && cmd.code != CMD_RESULT && cmd.code != CMD_CAP)
    |=> (rsp.valid && rsp.code == `STS_RC_FAILURE))
    else $error("command not rejected in failure");
  a_fail_code: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s.failed) |-> (rsp.valid && rsp.code == `STS_RC_FAILURE
      && status_code == `STS_RC_FAILURE))
    else $error("failure code missing on failure entry");
  a_seed_entropy: assert property (@(posedge clk) disable iff (!nrst)
    main_seed_valid |-> ($past(s.nbytes) == 7'd64 && $past(s.credit) >= 10'd414
      && main_generator_seed == $past(s.seed)))
    else $error("seed released without full width or entropy");
  a_stir_reseeds: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == ST_IDLE && cmd.valid && cmd.code == CMD_STIR)
    |=> (s.st == ST_RESEED && s.nbytes == 7'd0 && ent_ready))
    else $error("stir command did not start a reseed");
  a_gen_route: assert property (@(posedge clk) disable iff (!nrst)
    (transient_gen_req |-> rnd_primary) and (main_gen_req |-> !rnd_primary))
    else $error("random request routed to wrong generator");
  a_hw_check: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == ST_HW && hw_sensor_flags != 8'h00) |=> s.failed)
    else $error("sensor flag did not cause failure");
  a_rct_fail: assert property (@(posedge clk) disable iff (!nrst)
    (ent_take && s.have && ent.data == s.last && s.repetition_count_test == 3'd3) |=> s.failed)
    else $error("repetition count test missed a failure");
  a_crc_fail: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == ST_CRC && fw.valid && fw.last
      && (crc16_byte(s.crc, fw.data) ^ 16'hffff) != fw_crc_ref) |=> s.failed)
    else $error("integrity mismatch did not cause failure");
  a_full_rerun: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == ST_IDLE && cmd.valid && cmd.code == CMD_FULL && cmd.full)
    |=> (s.st == ST_CRC && s.algo[1] && fw_req))
    else $error("full test did not rerun integrity check");
  a_kat_clear: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == ST_KAT && s.kat_busy && kat_done && kat_pass && s.tst == T_SHA256)
    |=> (!s.algo[2] && s.tst == T_SHA384 ##1 kat_start))
    else $error("hash test pass not recorded");
  a_ready_gate: assert property (@(posedge clk) disable iff (!nrst)
    crypto_enable |-> (s.algo == 32'h00000000 && !s.failed))
    else $error("crypto enabled before tests completed");
  a_result_word: assert property (@(posedge clk) disable iff (!nrst)
    (cmd_ready && cmd.valid && cmd.code == CMD_RESULT)
    |=> (rsp.valid && (rsp.code == 32'h00000000) == (rsp.algo == 32'h00000000 && !s.failed)))
    else $error("result status word inconsistent with list");

endmodule // sts_supervisor

/* File: sts_defs.svh */
// constants of the self-test and random generator supervisor
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH

// seeding of the main generator
`define STS_SEED_BYTES 7'd64
`define STS_MIN_ENTROPY 10'd414
`define STS_CREDIT_MAX 10'h3ff

// entropy health tests
`define STS_RCT_CUTOFF 3'd5
`define STS_APT_CUTOFF 5'd13

// firmware integrity code, reflected form
`define STS_CRC_INIT 16'hffff
`define STS_CRC_POLY 16'h8408
`define STS_CRC_XOROUT 16'hffff

// algorithm status field
`define STS_ALGO_RESET 32'h0000000e
`define STS_BIT_SHA1 1
`define STS_BIT_SHA256 2
`define STS_BIT_SHA384 3

// return codes
`define STS_RC_SUCCESS 32'h00000000
`define STS_RC_FAILURE 32'h000000f1
`define STS_RC_TESTING 32'h000000f2

// known-answer test sizes in bytes
`define STS_KAT_SEED_LEN 7'd64
`define STS_KAT_DRBG_OUT 7'd32
`define STS_KAT_MSG_LEN 7'd16
`define STS_KAT_SHA1_OUT 7'd20
`define STS_KAT_SHA256_OUT 7'd32
`define STS_KAT_SHA384_OUT 7'd48

`endif

/* File: sts_pkg.sv */
// types of the self-test and random generator supervisor
package sts_pkg;

  typedef enum logic [2:0] {
    CMD_STIR, CMD_FULL, CMD_INCR, CMD_RESULT, CMD_CAP, CMD_OTHER
  } sts_cmd_e;

  typedef enum logic [2:0] {
    ST_HW, ST_ENT, ST_CRC, ST_KAT, ST_IDLE, ST_RESEED, ST_FAIL
  } sts_state_e;

  typedef enum logic [1:0] {T_DRBG, T_SHA1, T_SHA256, T_SHA384} sts_test_e;

  typedef struct packed {
    logic valid;
    sts_cmd_e code;
    logic full;
  } sts_cmd_s;

  typedef struct packed {
    logic valid;
    logic [31:0] code;
    logic [31:0] algo;
  } sts_rsp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [3:0] credit;
  } sts_ent_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } sts_fw_s;

  typedef struct packed {
    logic [6:0] seed_len;
    logic [6:0] msg_len;
    logic [6:0] out_len;
  } sts_kat_cfg_s;

  typedef struct packed {
    sts_state_e st;
    sts_test_e tst;
    logic kat_busy;
    logic kat_start;
    logic failed;
    logic pend;
    logic crc_ok;
    logic [31:0] algo;
    logic [15:0] crc;
    logic [511:0] seed;
    logic [511:0] seed_out;
    logic seed_vld;
    logic [6:0] nbytes;
    logic [9:0] credit;
    logic have;
    logic [7:0] last;
    logic [2:0] repetition_count_test;
    logic [8:0] apt_n;
    logic [7:0] apt_ref;
    logic [4:0] apt_cnt;
    sts_rsp_s rsp;
  } sts_reg_s;

endpackage

/* File: sts_host_model.sv */
// partner model: entropy source, firmware store and test engine
`timescale 1ns/1ns
`include "sts_defs.svh"
module sts_host_model
  import sts_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] credit,
  input wire logic stuck,
  input wire logic crc_bad,
  input wire logic [2:0] kfail,
  input wire logic ent_ready,
  output sts_ent_s ent,
  input wire logic fw_req,
  output sts_fw_s fw,
  output logic [15:0] fw_crc_ref,
  input wire logic kat_start,
  input wire sts_test_e kat_sel,
  output logic kat_done,
  output logic kat_pass
);
  // ==== firmware image and its code
  logic [7:0] img [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
  logic [7:0] byt = 8'h01;
  logic [511:0] exp_seed = '0;
  logic [1:0] idx = 2'h0;
  int taken = 0, last_taken = 0, fw_runs = 0, kcnt = 0;
  sts_test_e ksel;
  initial kat_done = 1'b0;
  initial kat_pass = 1'b0;

  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = `STS_CRC_INIT;
    for (int i = 0; i < 4; i++) begin
      c = c ^ {8'h00, img[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ `STS_CRC_POLY) : (c >> 1);
      end
    end
    return c ^ `STS_CRC_XOROUT;
  endfunction

  // released lines show the inverse of their next value
  assign fw_crc_ref = crc_of() ^ {15'h0000, crc_bad};
  assign ent = '{ent_ready, ent_ready ? byt : ~byt, credit};
  assign fw = '{fw_req, fw_req ? img[idx] : ~img[idx], idx == 2'h3};

  always @(posedge clk) begin
    if (ent_ready) begin
      byt <= stuck ? byt : byt + 8'h01;
      exp_seed <= {exp_seed[503:0], byt};
      taken <= taken + 1;
    end else if (taken != 0) begin
      last_taken <= taken;
      taken <= 0;
    end
    if (fw_req) begin
      idx <= idx + 2'h1;
      if (idx == 2'h3) fw_runs <= fw_runs + 1;
    end
    kat_done <= 1'b0;
    kat_pass <= ~kat_pass;
    if (kcnt == 1) begin
      kat_done <= 1'b1;
      kat_pass <= !(kfail[2] && kfail[1:0] == ksel);
    end
    if (kcnt != 0) kcnt <= kcnt - 1;
    if (kat_start) begin
      kcnt <= 1 + 3 * kat_sel;
      ksel <= kat_sel;
    end
    if (!nrst) kcnt <= 0;
  end
endmodule // sts_host_model

/* File: testbench.sv */
// self-checking bench of the self-test supervisor
`timescale 1ns/1ns
`include "sts_defs.svh"
module testbench
  import sts_pkg::*;
();
  // ==== signals
  logic clk, nrst, cmd_ready, failure, ent_ready, main_seed_valid, fw_req, kat_start;
  logic kat_done, kat_pass, rnd_req, rnd_primary, main_gen_req, transient_gen_req;
  logic crypto_enable, data_out_enable, stuck, crc_bad;
  logic [2:0] kfail;
  logic [3:0] credit;
  logic [7:0] hw_sensor_flags;
  logic [15:0] fw_crc_ref;
  logic [31:0] status_code;
  logic [511:0] main_generator_seed;
  sts_cmd_s cmd;
  sts_rsp_s rsp, r;
  sts_ent_s ent;
  sts_fw_s fw;
  sts_test_e kat_sel, nxt;
  sts_kat_cfg_s kat_cfg;
  sts_kat_cfg_s cfgs [4] = '{'{`STS_KAT_SEED_LEN, 7'h00, `STS_KAT_DRBG_OUT},
    '{7'h00, `STS_KAT_MSG_LEN, `STS_KAT_SHA1_OUT}, '{7'h00, `STS_KAT_MSG_LEN,
    `STS_KAT_SHA256_OUT}, '{7'h00, `STS_KAT_MSG_LEN, `STS_KAT_SHA384_OUT}};
  sts_cmd_e bad_ops [4] = '{CMD_STIR, CMD_FULL, CMD_INCR, CMD_OTHER};
  int fails = 0, cmp_count = 0, cyc = 0, rsps = 0, need = 64, n;

  sts_supervisor sts_supervisor_inst (.*);
  sts_host_model sts_host_model_inst (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==== tasks
  task automatic chk(input logic [511:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic boot(input logic [7:0] hw, input logic stk, bad);
    @(posedge clk);
    nrst <= 1'b0;
    hw_sensor_flags <= hw;
    stuck <= stk;
    crc_bad <= bad;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({failure, cmd_ready, crypto_enable, data_out_enable}, 4'h1, "reset");
    while (cmd_ready !== 1'b1) @(negedge clk);
  endtask

  task automatic pulse(input sts_cmd_e c, input logic f);
    @(posedge clk);
    cmd <= '{1'b1, c, f};
    @(posedge clk);
    cmd.valid <= 1'b0;
  endtask

  task automatic get_rsp();
    r = '0;
    while (r.valid !== 1'b1) begin
      @(negedge clk);
      r = rsp;
    end
  endtask

  task automatic send(input sts_cmd_e c, input logic f);
    while (cmd_ready !== 1'b1) @(negedge clk);
    pulse(c, f);
    get_rsp();
  endtask

  task automatic gen(input logic m, t);
    @(posedge clk);
    rnd_req <= 1'b1;
    rnd_primary <= 1'b1;
    @(negedge clk);
    chk({main_gen_req, transient_gen_req}, {1'b0, t}, "primary");
    @(posedge clk);
    rnd_primary <= 1'b0;
    @(negedge clk);
    chk({main_gen_req, transient_gen_req}, {m, 1'b0}, "plain");
    @(posedge clk);
    rnd_req <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (rsp.valid === 1'b1) rsps++;
    if (nrst !== 1'b1) nxt <= T_DRBG;
    else if (kat_start === 1'b1) begin
      chk(kat_sel, nxt, "order");
      chk(kat_cfg, cfgs[kat_sel], "sizes");
      nxt <= sts_test_e'(kat_sel + 2'h1);
    end
    if (main_seed_valid === 1'b1) begin
      chk(main_generator_seed, sts_host_model_inst.exp_seed, "seed");
      chk(sts_host_model_inst.last_taken, need, "bytes");
    end
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end

  // ==== sequence
  initial begin
    nrst = 1'b0;
    cmd = '0;
    rnd_req = 1'b0;
    rnd_primary = 1'b0;
    hw_sensor_flags = 8'h00;
    credit = 4'h8;
    stuck = 1'b0;
    crc_bad = 1'b0;
    kfail = 3'h0;
    // sensor flag, bad code, stuck entropy
    for (int k = 0; k < 3; k++) begin
      boot(k == 0 ? 8'h04 : 8'h00, k == 2, k == 1);
      chk({failure, status_code}, {1'b1, `STS_RC_FAILURE}, "boot");
    end
    boot(8'h00, 1'b0, 1'b0);
    chk(crypto_enable, 1'b1, "ready");
    send(CMD_RESULT, 1'b0);
    chk({r.code, r.algo}, {`STS_RC_SUCCESS, 32'h0}, "result");
    gen(1'b1, 1'b1);
    // 69 bytes of 6 bits reach the minimum
    credit <= 4'h6;
    need <= 69;
    send(CMD_STIR, 1'b0);
    chk(main_seed_valid, 1'b1, "reseed");
    @(posedge clk);
    credit <= 4'h8;
    need <= 64;
    @(negedge clk);
    n = rsps;
    for (int k = 0; k < 3; k++) pulse(k == 0 ? CMD_RESULT : k == 1 ? CMD_CAP : CMD_OTHER, 1'b0);
    repeat (2) @(negedge clk);
    chk(rsps, n + 3, "queries");
    n = rsps;
    pulse(CMD_INCR, 1'b0);
    pulse(CMD_RESULT, 1'b0);
    get_rsp();
    repeat (3) @(negedge clk);
    chk(rsps, n + 1, "busy");
    for (int k = 1; k >= 0; k--) begin
      n = sts_host_model_inst.fw_runs;
      send(CMD_FULL, k[0]);
      chk(sts_host_model_inst.fw_runs, n + k, "rerun");
      send(CMD_RESULT, 1'b0);
      chk(r.algo, 32'h0, "bits");
    end
    kfail <= {1'b1, T_SHA256};
    send(CMD_FULL, 1'b1);
    chk(r.code, `STS_RC_FAILURE, "fail");
    @(negedge clk);
    chk({data_out_enable, crypto_enable}, 2'h0, "blocked");
    gen(1'b0, 1'b0);
    send(CMD_RESULT, 1'b0);
    chk({r.code, r.algo}, {`STS_RC_FAILURE, 32'h0000000c}, "list");
    send(CMD_CAP, 1'b0);
    chk(r.code, `STS_RC_SUCCESS, "cap");
    for (int k = 0; k < 4; k++) begin
      send(bad_ops[k], 1'b1);
      chk({r.code, r.algo}, {`STS_RC_FAILURE, 32'h0}, "reject");
    end
    repeat (50) @(negedge clk);
    chk(failure, 1'b1, "hold");
    kfail <= 3'h0;
    boot(8'h00, 1'b0, 1'b0);
    chk(failure, 1'b0, "cleared");
    wrap_up();
  end
endmodule // testbench
